// file: eeis_top.sv
`timescale 1ns/1ps
// Event input conditioning and source selection
module eeis_top
  import eeis_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             event_pin,
  input  wire logic             cfg_wr,
  input  wire logic             cfg_hold,
  input  wire logic [1:0]       cfg_edge,
  input  wire logic [7:0]       cfg_presc,
  input  wire logic             sel_wr,
  input  wire logic [SRC_W-1:0] sel_pattern,
  input  wire logic             can_en_wr,
  input  wire logic [SRC_W-1:0] can_en_pattern,
  input  wire logic             can1_evt,
  input  wire logic             can2_evt,
  input  wire logic             cop_trig,
  output logic [SRC_W-1:0]      src_q,
  output logic [7:0]            edge_cnt_q,
  output logic                  main_cpu_event
);
  // Filter outputs and edge counting
  logic             hold_q, hold_d;
  logic             lvl, rise_p, fall_p;
  logic             acc, fire;
  logic [1:0]       edge_q, edge_d;
  logic [7:0]       presc_q, presc_d, cnt_d;

  // Source selection and pulse shaping
  logic [SRC_W-1:0] src_d;
  logic [SRC_W-1:0] src_evt, src_hit;
  logic             evt_q, evt_d;
  logic             pulse_q, pulse_d;

  // Edge decode kept in one place
  function automatic logic edge_take(
    input logic [1:0] code,
    input logic       rise,
    input logic       fall
  );
    logic take;
    case (code)
      EDGE_RISE: take = rise;
      EDGE_FALL: take = fall;
      EDGE_BOTH: take = rise | fall;
      default:   take = 1'b0; // Code zero counts nothing
    endcase
    return take;
  endfunction

  // Glitch filter on the external pin
  eeis_filter u_filt (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .pin_in   (event_pin),
    .hold_sel (hold_q),
    .level_q  (lvl),
    .rise_p   (rise_p),
    .fall_p   (fall_p)
  );

  // Configuration and shared source setting
  always_comb begin
    hold_d  = hold_q;
    edge_d  = edge_q;
    presc_d = presc_q;
    src_d   = src_q;
    if (cfg_wr) begin
      hold_d  = cfg_hold;
      edge_d  = cfg_edge;
      // Zero count would fire on every accepted edge; clamp to one
      presc_d = (cfg_presc == 8'h00) ? PRESC_RESET : cfg_presc;
    end
    // Selector write wins a same-cycle tie; software must not race them
    if (can_en_wr) src_d = can_en_pattern;
    if (sel_wr)    src_d = sel_pattern;
  end

  // Edge qualify and prescale
  always_comb begin
    acc   = edge_take(edge_q, rise_p, fall_p);
    fire  = 1'b0;
    cnt_d = edge_cnt_q;
    if (acc) begin
      if (edge_cnt_q + 8'h01 >= presc_q) begin
        fire  = 1'b1;
        cnt_d = 8'h00;
      end else begin
        cnt_d = edge_cnt_q + 8'h01;
      end
    end
  end

  // Strobe of each source on its own select bit; reserved bits stay dead
  always_comb begin
    src_evt               = '0;
    src_evt[SRC_CAN1_BIT] = can1_evt;
    src_evt[SRC_CAN2_BIT] = can2_evt;
    src_evt[SRC_COP_BIT]  = cop_trig;
    src_evt[SRC_PIN_BIT]  = fire;
  end

  // One gate per select bit; several set bits simply OR together
  for (genvar gi = 0; gi < SRC_W; gi++) begin : g_src
    assign src_hit[gi] = src_q[gi] & src_evt[gi];
  end

  // Registered OR, then a pulse on its rising edge only
  always_comb begin
    evt_d   = |src_hit;
    pulse_d = evt_d & !evt_q;
  end

  // Registers; synchronous reset restores the power-up defaults
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hold_q     <= HOLD_RESET;
      edge_q     <= EDGE_RISE;
      presc_q    <= PRESC_RESET;
      src_q      <= SRC_RESET;
      edge_cnt_q <= 8'h00;
      evt_q      <= 1'b0;
      pulse_q    <= 1'b0;
    end else begin
      hold_q     <= hold_d;
      edge_q     <= edge_d;
      presc_q    <= presc_d;
      src_q      <= src_d;
      edge_cnt_q <= cnt_d;
      evt_q      <= evt_d;
      pulse_q    <= pulse_d;
    end
  end

  // Sources are treated as strobes; a held source still gives one pulse
  // Driven straight from a flop so the cpu input never sees a glitch
  assign main_cpu_event = pulse_q;

  // Pulse shape and source delivery
  AST_PULSE_ONE: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    main_cpu_event |=> !main_cpu_event)
    else $error("event longer than one cycle");

  AST_PIN_EVT: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (fire && src_q == SRC_RESET && !$past(fire)) |=> main_cpu_event)
    else $error("pin event lost");

  AST_CAN1: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (can1_evt && src_q == 32'h0000_0001 && !evt_q) |=> main_cpu_event)
    else $error("can one event lost");

  AST_CAN2: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (can2_evt && src_q == 32'h0000_0002 && !evt_q) |=> main_cpu_event)
    else $error("can two event lost");

  AST_COP: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (cop_trig && src_q == 32'h0000_0008 && !evt_q) |=> main_cpu_event)
    else $error("coprocessor trigger lost");

  AST_RESERVED: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (src_q == 32'h0000_0004) |=> !evt_q)
    else $error("reserved source fired");

  AST_NO_SPURIOUS: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!can1_evt && !can2_evt && !cop_trig && !fire) |=> !main_cpu_event)
    else $error("event without a source strobe");

  // Shared source setting and its default
  AST_RESET_SRC: assert property (
    @(posedge ref_clk)
    sys_rst |=> src_q == SRC_RESET)
    else $error("source not defaulted by reset");

  AST_SHARED: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (can_en_wr && !sel_wr) |=> src_q == $past(can_en_pattern))
    else $error("shared source not written");

  AST_SEL_WINS: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sel_wr |=> src_q == $past(sel_pattern))
    else $error("selector write lost");

  // Prescaler count, clamp and clearing
  AST_CLAMP: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (cfg_wr && cfg_presc == 8'h00) |=> presc_q == PRESC_RESET)
    else $error("zero prescale not clamped");

  AST_PRESC: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    fire |-> edge_cnt_q + 8'h01 >= presc_q)
    else $error("event before prescale count");

  AST_CNT_STEP: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (acc && !fire) |=> edge_cnt_q == $past(edge_cnt_q) + 8'h01)
    else $error("accepted edge not counted");

  AST_CNT_HOLD: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !acc |=> $stable(edge_cnt_q))
    else $error("count moved without an edge");

  AST_CNT_CLEAR: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    fire |=> edge_cnt_q == 8'h00)
    else $error("prescaler not cleared");

  // Edge selection and filtered level
  AST_FALL_ONLY: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (edge_q == EDGE_FALL && rise_p) |-> !fire)
    else $error("rising edge counted in falling mode");

  AST_RISE_ONLY: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (edge_q == EDGE_RISE && fall_p) |-> !acc)
    else $error("falling edge counted in rising mode");

  AST_NONE_CODE: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (edge_q == 2'h0) |-> !fire)
    else $error("event with edge code zero");

  AST_LEVEL_UP: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    rise_p |=> lvl)
    else $error("rise not taken into level");

  AST_LEVEL_DOWN: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    fall_p |=> !lvl)
    else $error("fall not taken into level");

  // Main scenarios
  COV_PIN: cover property (@(posedge ref_clk) fire && main_cpu_event == 1'b0);
  COV_COP: cover property (@(posedge ref_clk) src_q[SRC_COP_BIT] && cop_trig);
  COV_BOTH: cover property (@(posedge ref_clk) edge_q == EDGE_BOTH && fall_p);
  COV_SHARED: cover property (@(posedge ref_clk) can_en_wr && !sel_wr);
  COV_PRESC: cover property (@(posedge ref_clk) fire && presc_q > 8'h01);
endmodule // eeis_top

// file: eeis_pkg.sv
// Contract
// - Pin edge accepted only after new level holds 15 ns or 50 ns.
// - Edge type code 1 rising, 2 falling, 3 both.
// - Event raised after programmed count of accepted edges, 1 to 255.
// - Source bit 0 CAN one, bit 1 CAN two, bit 3 coprocessor trigger.
// - Source bit 4 selects conditioned pin; default after reset.
// - Other source bits reserved; no source attached to them.
// - CAN enable path and selector share one source; last writer wins.
package eeis_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned HOLD_SHORT_NS  = 15;
  localparam int unsigned HOLD_LONG_NS   = 50;
  // Least times round up
  localparam int unsigned HOLD_SHORT_CYC = (HOLD_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_LONG_CYC  = (HOLD_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HCNT_W         = 4;
  localparam int unsigned SRC_W          = 32;
  localparam int unsigned SRC_CAN1_BIT   = 0;
  localparam int unsigned SRC_CAN2_BIT   = 1;
  localparam int unsigned SRC_COP_BIT    = 3;
  localparam int unsigned SRC_PIN_BIT    = 4;
  localparam logic [31:0] SRC_RESET      = 32'h0000_0010;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;
  localparam logic [7:0]  PRESC_RESET    = 8'h01;
  localparam logic        HOLD_RESET     = 1'h0;
endpackage

// file: eeis_filter.sv
`timescale 1ns/1ps
// Glitch filter: output follows pin only after stable hold time
module eeis_filter
  import eeis_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  input  wire logic hold_sel,
  output logic      level_q,
  output logic      rise_p,
  output logic      fall_p
);
  logic [HCNT_W-1:0] cnt_q, cnt_d, need;
  logic              level_d;

  // Count cycles the pin differs from the accepted level
  always_comb begin
    need    = hold_sel ? HCNT_W'(HOLD_LONG_CYC) : HCNT_W'(HOLD_SHORT_CYC);
    cnt_d   = '0;
    level_d = level_q;
    rise_p  = 1'b0;
    fall_p  = 1'b0;
    if (pin_in != level_q) begin
      if (cnt_q + 1'b1 >= need) begin
        level_d = pin_in;
        rise_p  = pin_in;
        fall_p  = !pin_in;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Counter and accepted level; both cleared by reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  AST_HOLD_SHORT: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!hold_sel && $changed(level_q)) |-> $past(pin_in, 4) == level_q)
    else $error("pin accepted before short hold");
  AST_HOLD_LONG: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (hold_sel && $past(hold_sel, 13) && $changed(level_q))
      |-> $past(pin_in, 13) == level_q)
    else $error("pin accepted before long hold");
endmodule // eeis_filter

// file: eeis_far.sv
`timescale 1ns/1ps
// Far side: event pin and source strobes
module eeis_far (
  input  wire logic ref_clk,
  output logic      event_pin,
  output logic      can1_evt,
  output logic      can2_evt,
  output logic      cop_trig
);
  initial {event_pin, can1_evt, can2_evt, cop_trig} = 4'h0;
  // Pin level held n cycles, moved just after an edge
  task automatic pin(input logic v, input int n);
    event_pin = v;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One-cycle strobes; mask bit 0 can1, 1 can2, 2 cop
  task automatic strobe(input logic [2:0] m);
    {cop_trig, can2_evt, can1_evt} = m;
    @(posedge ref_clk);
    #1 {cop_trig, can2_evt, can1_evt} = 3'h0;
  endtask
endmodule // eeis_far

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import eeis_pkg::*;
  logic             ref_clk = 1'h0, sys_rst = 1'h1, cfg_wr = 1'h0, cfg_hold = 1'h0;
  logic             sel_wr = 1'h0, can_en_wr = 1'h0;
  logic [1:0]       cfg_edge = 2'h1;
  logic [7:0]       cfg_presc = 8'h01, edge_cnt_q;
  logic [SRC_W-1:0] sel_pattern = '0, can_en_pattern = '0, src_q;
  logic             event_pin, can1_evt, can2_evt, cop_trig, main_cpu_event;
  int               mismatches = 0, n_checks = 0, ev_n = 0, b, p, k, r;
  eeis_top uut (.ref_clk, .sys_rst, .event_pin, .cfg_wr, .cfg_hold, .cfg_edge,
    .cfg_presc, .sel_wr, .sel_pattern, .can_en_wr, .can_en_pattern, .can1_evt,
    .can2_evt, .cop_trig, .src_q, .edge_cnt_q, .main_cpu_event);
  eeis_far far (.ref_clk, .event_pin, .can1_evt, .can2_evt, .cop_trig);
  initial forever #2 ref_clk = ~ref_clk;
  // Tally of pulses reaching the main cpu
  always @(posedge ref_clk) if (main_cpu_event === 1'h1) ev_n++;
  task automatic chk_n(input int exp, input string m);
    repeat (4) @(posedge ref_clk);
    #1 n_checks++;
    if (ev_n - b != exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: %0d events", $time, m, ev_n - b);
    end
    b = ev_n;
  endtask
  task automatic chk_v(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: %h", $time, m, got);
    end
  endtask
  task automatic rst();
    sys_rst = 1'h1;
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'h0;
    b = ev_n;
  endtask
  task automatic cfg(input logic h, input logic [1:0] e, input logic [7:0] pr);
    {cfg_hold, cfg_edge, cfg_presc} = {h, e, pr};
    cfg_wr = 1'h1;
    @(posedge ref_clk);
    #1 cfg_wr = 1'h0;
  endtask
  task automatic sel(input logic [31:0] v, input logic can);
    if (can) {can_en_pattern, can_en_wr} = {v, 1'h1};
    else {sel_pattern, sel_wr} = {v, 1'h1};
    @(posedge ref_clk);
    #1;
    if (can) can_en_wr = 1'h0;
    else sel_wr = 1'h0;
  endtask
  task automatic pulses(input int n, w);
    repeat (n) begin
      far.pin(1'h1, w);
      far.pin(1'h0, w);
    end
  endtask
  // Rise and fall counts are equal for whole pulses
  function automatic int exp_ev(int e, n, pr);
    return (n * e[0] + n * e[1]) / pr;
  endfunction
  // Edges left in the prescaler after the last event
  function automatic int exp_res(int e, n, pr);
    return (n * e[0] + n * e[1]) % pr;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence: defaults, hold, edges, sources
  initial begin
    void'($urandom(4516));
    rst();
    chk_v(src_q, SRC_RESET, "reset source");
    pulses(2, 4);
    chk_n(2, "default pin");
    cfg(1'h0, EDGE_RISE, 8'h00);
    pulses(2, 4);
    chk_n(2, "zero prescale");
    $display("defaults done");
    for (int h = 0; h < 2; h++) begin
      k = h ? HOLD_LONG_CYC : HOLD_SHORT_CYC;
      rst();
      cfg(h[0], EDGE_RISE, 8'h01);
      pulses(3, k - 1);
      chk_n(0, "glitch");
      pulses(1, k);
      chk_n(1, "held edge");
    end
    $display("hold done");
    for (int e = 0; e < 4; e++) begin
      rst();
      p = $urandom_range(4, 1);
      cfg(1'h0, e[1:0], p[7:0]);
      r = $urandom_range(9, 1);
      pulses(r, 4 + $urandom_range(3, 0));
      chk_n(exp_ev(e, r, p), "edge count");
      chk_v(edge_cnt_q, exp_res(e, r, p), "residual count");
    end
    $display("edges done");
    rst();
    for (int i = 0; i < 3; i++) begin
      sel(32'h1 << (i == 2 ? SRC_COP_BIT : i), 1'h0);
      far.strobe(3'h1 << i);
      chk_n(1, "source strobe");
    end
    sel(32'h4, 1'h0);
    far.strobe(3'h7);
    pulses(1, 4);
    chk_n(0, "reserved bit");
    sel(32'h1, 1'h0);
    sel(32'h2, 1'h1);
    chk_v(src_q, 32'h2, "shared source");
    far.strobe(3'h1);
    chk_n(0, "old source");
    far.strobe(3'h2);
    chk_n(1, "last writer");
    $display("sources done");
    summarize();
  end
  // Watchdog: tests need under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule // tb
